// File: src/peripheral_dma_channel.sv
/*
 * peripheral dma channel pair: avalon-mm register slave, receive and transmit channels that move
 * items between the peripheral holding registers and memory through one bus matrix port.
 * assumes one clock, the peripheral's ready strobes on the same clock, and a memory port that
 * answers each request with mem_done (and read data for a transmit read).
 */
// The Avalon-MM register port was decided locally.
// How it works
// RULE1 - ten registers at 0x100 to 0x124
// RULE2 - receive address is where received data goes
// RULE3 - transmit address is where outgoing data comes
// RULE4 - receive count zero halts receive transfers
// RULE5 - transmit count zero halts transmit transfers
// RULE6 - each direction has a next address
// RULE7 - each direction has a next count
// RULE8 - half duplex shares pointer and counter storage
// RULE9 - bit 0 enables receive unless bit 1
// RULE10 - bit 8 enables transmit, bit 1 disables receive
// RULE11 - bit 9 disables transmit; zero no effect
// RULE12 - half duplex receive enable clears transmit
// RULE13 - half duplex transmit enable needs no receive enable
// RULE14 - half duplex receive disable stops transmit too
// RULE15 - half duplex transmit disable stops receive too
// RULE16 - software never sets both enables half duplex
// RULE17 - address advances by 1, 2 or 4
// RULE18 - empty current count reloads from next registers
// RULE19 - both counts zero stop and raise flags
// RULE20 - status shows enables in bits 0, 8
// RULE21 - counter high bits zero; all reset to zero
// RULE22 - current count drops by one per item
`timescale 1ns/1ps
`include "peripheral_dma_channel_regs.svh"
module peripheral_dma_channel #(
   parameter int ADDR_W = 12,
   parameter bit HALF_DUPLEX = 1'b0
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic rx_ready,
   input wire logic [31:0] rx_holding_reg,
   input wire logic tx_ready,
   output logic [31:0] tx_holding_reg,
   output logic tx_load,
   input wire peripheral_dma_channel_pkg::item_size_t item_size,
   output peripheral_dma_channel_pkg::mem_req_t mem_req,
   input wire logic mem_done,
   input wire logic [31:0] mem_rdata,
   output peripheral_dma_channel_pkg::periph_flags_t flags
);
   typedef enum logic [1:0] {st_idle, st_rx_wr, st_tx_rd} mover_state_t;

   // the offset decode needs twelve address bits; refused while elaborating
   if (ADDR_W < 12) begin : g_addr_chk
      $error("ADDR_W must reach offset 0x124");
   end

   // byte enable merge, used for the address and count registers
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] step(input peripheral_dma_channel_pkg::item_size_t s);
      unique case (s)
         peripheral_dma_channel_pkg::size_byte: step = 32'h0000_0001;
         peripheral_dma_channel_pkg::size_half: step = 32'h0000_0002;
         peripheral_dma_channel_pkg::size_word: step = 32'h0000_0004;
         default: step = 32'h0000_0004;
      endcase
   endfunction

   // index 0 receive, 1 transmit; in half duplex both names use index 0
   logic [31:0] cur_addr_ff [2];
   logic [15:0] cur_count_ff [2];
   logic [31:0] next_addr_ff [2];
   logic [15:0] next_count_ff [2];
   logic rx_en_ff, tx_en_ff;
   logic acc_ff;
   logic [31:0] rdata_ff;
   mover_state_t st_ff;
   logic rx_pend_ff, tx_pend_ff;
   logic item_done;
   logic item_dir;

   wire logic [11:0] ofs = avs_address[11:0];
   wire logic wr_take = avs_write && acc_ff; // writes land where waitrequest is seen low
   wire logic rd_take = avs_read && !acc_ff;
   wire logic rx_sel = 1'b0;
   wire logic tx_sel = HALF_DUPLEX ? 1'b0 : 1'b1; // RULE8
   wire logic [31:0] wcount = merge(32'h0000_0000, avs_writedata, avs_byteenable);
   // control write bits, one wire each so the enable process stays purely non-blocking
   wire logic ctl_re = avs_writedata[`BIT_RX_REQ_ENABLE];
   wire logic ctl_rd = avs_writedata[`BIT_RX_REQ_DISABLE];
   wire logic ctl_te = avs_writedata[`BIT_TX_REQ_ENABLE];
   wire logic ctl_td = avs_writedata[`BIT_TX_REQ_DISABLE];

   // one wait state per access: request seen, answered next edge
   always_ff @(posedge clk) begin
      if (srst) begin
         acc_ff <= 1'b0;
      end else begin
         acc_ff <= (avs_read || avs_write) && !acc_ff;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && !acc_ff);
      end
   end

   // read mux; control register is write-only and unmapped offsets read zero
   always_ff @(posedge clk) begin
      if (srst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (rd_take) begin
         unique case (ofs)
            `OFS_RX_CUR_ADDR: avs_readdata <= cur_addr_ff[rx_sel]; // RULE1
            `OFS_RX_CUR_COUNT: avs_readdata <= {16'h0000, cur_count_ff[rx_sel]}; // RULE21
            `OFS_TX_CUR_ADDR: avs_readdata <= cur_addr_ff[tx_sel];
            `OFS_TX_CUR_COUNT: avs_readdata <= {16'h0000, cur_count_ff[tx_sel]};
            `OFS_RX_NEXT_ADDR: avs_readdata <= next_addr_ff[rx_sel];
            `OFS_RX_NEXT_COUNT: avs_readdata <= {16'h0000, next_count_ff[rx_sel]};
            `OFS_TX_NEXT_ADDR: avs_readdata <= next_addr_ff[tx_sel];
            `OFS_TX_NEXT_COUNT: avs_readdata <= {16'h0000, next_count_ff[tx_sel]};
            `OFS_CHANNEL_STATE: begin
               avs_readdata <= 32'h0000_0000;
               avs_readdata[`BIT_RX_REQ_ENABLE] <= rx_en_ff; // RULE20
               avs_readdata[`BIT_TX_REQ_ENABLE] <= tx_en_ff;
            end
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // enable state from control writes; both set in one write wins for receive in half duplex
   always_ff @(posedge clk) begin
      if (srst) begin
         rx_en_ff <= 1'b0;
         tx_en_ff <= 1'b0;
      end else if (wr_take && ofs == `OFS_CHANNEL_CONTROL && avs_byteenable[0] && avs_byteenable[1]) begin
         if (HALF_DUPLEX) begin
            if (ctl_rd || ctl_td) begin
               rx_en_ff <= 1'b0; // RULE14
               tx_en_ff <= 1'b0; // RULE15
            end else if (ctl_re) begin
               rx_en_ff <= 1'b1;
               tx_en_ff <= 1'b0; // RULE12
            end else if (ctl_te) begin
               tx_en_ff <= 1'b1; // RULE13
               rx_en_ff <= 1'b0;
            end
         end else begin
            if (ctl_rd) begin
               rx_en_ff <= 1'b0; // RULE10
            end else if (ctl_re) begin
               rx_en_ff <= 1'b1; // RULE9
            end
            if (ctl_td) begin
               tx_en_ff <= 1'b0; // RULE11
            end else if (ctl_te) begin
               tx_en_ff <= 1'b1; // RULE10
            end
         end
      end
   end

   // pointer and counter storage; software writes win over the mover in the same cycle
   generate
      for (genvar d = 0; d < 2; d++) begin : g_dir
         wire logic [11:0] o_ca = d ? `OFS_TX_CUR_ADDR : `OFS_RX_CUR_ADDR;
         wire logic [11:0] o_cc = d ? `OFS_TX_CUR_COUNT : `OFS_RX_CUR_COUNT;
         wire logic [11:0] o_na = d ? `OFS_TX_NEXT_ADDR : `OFS_RX_NEXT_ADDR;
         wire logic [11:0] o_nc = d ? `OFS_TX_NEXT_COUNT : `OFS_RX_NEXT_COUNT;
         // half duplex: both register names reach entry 0
         wire logic hit = HALF_DUPLEX ? (d == 0) : 1'b1; // RULE8
         wire logic w_ca = hit && wr_take && (ofs == `OFS_RX_CUR_ADDR || ofs == `OFS_TX_CUR_ADDR)
            && (HALF_DUPLEX || ofs == o_ca);
         wire logic w_cc = hit && wr_take && (ofs == `OFS_RX_CUR_COUNT || ofs == `OFS_TX_CUR_COUNT)
            && (HALF_DUPLEX || ofs == o_cc);
         wire logic w_na = hit && wr_take && (ofs == `OFS_RX_NEXT_ADDR || ofs == `OFS_TX_NEXT_ADDR)
            && (HALF_DUPLEX || ofs == o_na);
         wire logic w_nc = hit && wr_take && (ofs == `OFS_RX_NEXT_COUNT || ofs == `OFS_TX_NEXT_COUNT)
            && (HALF_DUPLEX || ofs == o_nc);
         wire logic adv = item_done && (HALF_DUPLEX ? (d == 0) : (item_dir == 1'(d)));
         wire logic reload = adv && cur_count_ff[d] == 16'h0001 && next_count_ff[d] != `RST_COUNT;
         always_ff @(posedge clk) begin
            if (srst) begin
               cur_addr_ff[d] <= `RST_ADDR; // RULE21
               cur_count_ff[d] <= `RST_COUNT;
               next_addr_ff[d] <= `RST_ADDR;
               next_count_ff[d] <= `RST_COUNT;
            end else begin
               if (w_ca) begin
                  cur_addr_ff[d] <= merge(cur_addr_ff[d], avs_writedata, avs_byteenable); // RULE2 RULE3
               end else if (reload) begin
                  cur_addr_ff[d] <= next_addr_ff[d]; // RULE18
               end else if (adv) begin
                  cur_addr_ff[d] <= cur_addr_ff[d] + step(item_size); // RULE17
               end
               if (w_cc) begin
                  cur_count_ff[d] <= wcount[15:0]; // RULE21
               end else if (reload) begin
                  cur_count_ff[d] <= next_count_ff[d];
               end else if (adv) begin
                  cur_count_ff[d] <= cur_count_ff[d] - 16'h0001; // RULE22
               end
               if (w_na) begin
                  next_addr_ff[d] <= merge(next_addr_ff[d], avs_writedata, avs_byteenable); // RULE6
               end else if (reload) begin
                  next_addr_ff[d] <= `RST_ADDR;
               end
               if (w_nc) begin
                  next_count_ff[d] <= wcount[15:0]; // RULE7
               end else if (reload) begin
                  next_count_ff[d] <= `RST_COUNT;
               end
            end
         end
      end
   endgenerate

   // zero count or disabled channel starts nothing; receive served first
   wire logic rx_go = rx_pend_ff && rx_en_ff && cur_count_ff[rx_sel] != `RST_COUNT; // RULE4
   wire logic tx_go = tx_pend_ff && tx_en_ff && cur_count_ff[tx_sel] != `RST_COUNT; // RULE5

   // a ready strobe is remembered until the mover serves it
   always_ff @(posedge clk) begin
      if (srst) begin
         rx_pend_ff <= 1'b0;
         tx_pend_ff <= 1'b0;
      end else begin
         rx_pend_ff <= rx_ready || (rx_pend_ff && !(st_ff == st_idle && rx_go));
         tx_pend_ff <= tx_ready || (tx_pend_ff && !(st_ff == st_idle && !rx_go && tx_go));
      end
   end

   // an item ends at the memory answer
   assign item_done = st_ff != st_idle && mem_done;
   assign item_dir = st_ff == st_tx_rd;

   // mover: one memory access per item
   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff <= st_idle;
         mem_req <= '0;
      end else begin
         unique case (st_ff)
            st_idle: begin
               if (rx_go) begin
                  st_ff <= st_rx_wr;
                  mem_req <= {1'b1, 1'b1, cur_addr_ff[rx_sel], rx_holding_reg, item_size}; // RULE2
               end else if (tx_go) begin
                  st_ff <= st_tx_rd;
                  mem_req <= {1'b1, 1'b0, cur_addr_ff[tx_sel], 32'h0000_0000, item_size}; // RULE3
               end
            end
            st_rx_wr, st_tx_rd: begin
               if (mem_done) begin
                  st_ff <= st_idle;
                  mem_req <= '0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         tx_holding_reg <= 32'h0000_0000;
         tx_load <= 1'b0;
      end else begin
         tx_load <= st_ff == st_tx_rd && mem_done;
         if (st_ff == st_tx_rd && mem_done) begin
            tx_holding_reg <= mem_rdata;
         end
      end
   end

   // flags follow the counts; cleared again by a nonzero count write
   always_ff @(posedge clk) begin
      if (srst) begin
         flags <= '0;
      end else begin
         flags.rx_end_flag <= cur_count_ff[rx_sel] == `RST_COUNT; // RULE19
         flags.rx_full_flag <= cur_count_ff[rx_sel] == `RST_COUNT && next_count_ff[rx_sel] == `RST_COUNT;
         flags.tx_end_flag <= cur_count_ff[tx_sel] == `RST_COUNT;
         flags.tx_empty_flag <= cur_count_ff[tx_sel] == `RST_COUNT && next_count_ff[tx_sel] == `RST_COUNT;
      end
   end

   property p_wait_one;
      @(posedge clk) disable iff (srst) (avs_read || avs_write) && avs_waitrequest && !acc_ff |=> !avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("access not answered after one wait state"); // RULE1
   property p_status;
      @(posedge clk) disable iff (srst) rd_take && ofs == `OFS_CHANNEL_STATE
         |=> avs_readdata[8] == $past(tx_en_ff) && avs_readdata[0] == $past(rx_en_ff);
   endproperty
   a_status: assert property (p_status) else $error("status bits wrong"); // RULE20
   property p_zero_halts;
      @(posedge clk) disable iff (srst) st_ff == st_idle && cur_count_ff[0] == 16'h0000 && !tx_go |=> st_ff == st_idle;
   endproperty
   a_zero_halts: assert property (p_zero_halts) else $error("transfer started at zero count"); // RULE4
   property p_dec;
      @(posedge clk) disable iff (srst) item_done && !HALF_DUPLEX && !item_dir && cur_count_ff[0] > 16'h0001
         && !(wr_take && ofs == `OFS_RX_CUR_COUNT) |=> cur_count_ff[0] == $past(cur_count_ff[0]) - 16'h0001;
   endproperty
   a_dec: assert property (p_dec) else $error("count did not drop by one"); // RULE22
   property p_rxdis;
      @(posedge clk) disable iff (srst) wr_take && ofs == `OFS_CHANNEL_CONTROL && avs_writedata[1]
         && avs_byteenable[0] && avs_byteenable[1] |=> !rx_en_ff;
   endproperty
   a_rxdis: assert property (p_rxdis) else $error("receive disable ignored"); // RULE10
   property p_hd_excl;
      @(posedge clk) disable iff (srst) HALF_DUPLEX |-> !(rx_en_ff && tx_en_ff);
   endproperty
   a_hd_excl: assert property (p_hd_excl) else $error("both directions on in half duplex"); // RULE12
   property p_full;
      @(posedge clk) disable iff (srst) !srst && cur_count_ff[0] == 16'h0000 && next_count_ff[0] == 16'h0000
         |=> flags.rx_full_flag;
   endproperty
   a_full: assert property (p_full) else $error("full flag missing"); // RULE19
   property p_txdis;
      @(posedge clk) disable iff (srst) wr_take && ofs == `OFS_CHANNEL_CONTROL && avs_writedata[9]
         && avs_byteenable[0] && avs_byteenable[1] |=> !tx_en_ff;
   endproperty
   a_txdis: assert property (p_txdis) else $error("transmit disable ignored"); // RULE11
   c_rx_item: cover property (@(posedge clk) disable iff (srst) st_ff == st_rx_wr ##[1:20] st_ff == st_idle);
   c_tx_item: cover property (@(posedge clk) disable iff (srst) tx_load);
   c_reload: cover property (@(posedge clk) disable iff (srst) item_done && cur_count_ff[0] == 16'h0001
      && next_count_ff[0] != 16'h0000);
endmodule

// File: src/peripheral_dma_channel_pkg.sv
/*
 * types of the peripheral dma channel pair.
 * assumes nothing beyond a systemverilog compiler.
 */
package peripheral_dma_channel_pkg;
   // item size of one transfer: byte, half-word, word
   typedef enum logic [1:0] {size_byte, size_half, size_word} item_size_t;
   // memory side request toward the bus matrix
   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
      item_size_t size;
   } mem_req_t;
   // flags back toward the peripheral
   typedef struct packed {
      logic rx_end_flag;
      logic rx_full_flag;
      logic tx_end_flag;
      logic tx_empty_flag;
   } periph_flags_t;
endpackage

// File: src/peripheral_dma_channel_regs.svh
/*
 * register offsets, field positions and reset values of the peripheral dma channel pair.
 * assumes inclusion by bare name; definitions only.
 */
`ifndef PERIPHERAL_DMA_CHANNEL_REGS_SVH
`define PERIPHERAL_DMA_CHANNEL_REGS_SVH
`define OFS_RX_CUR_ADDR 12'h100
`define OFS_RX_CUR_COUNT 12'h104
`define OFS_TX_CUR_ADDR 12'h108
`define OFS_TX_CUR_COUNT 12'h10c
`define OFS_RX_NEXT_ADDR 12'h110
`define OFS_RX_NEXT_COUNT 12'h114
`define OFS_TX_NEXT_ADDR 12'h118
`define OFS_TX_NEXT_COUNT 12'h11c
`define OFS_CHANNEL_CONTROL 12'h120
`define OFS_CHANNEL_STATE 12'h124
`define BIT_RX_REQ_ENABLE 0
`define BIT_RX_REQ_DISABLE 1
`define BIT_TX_REQ_ENABLE 8
`define BIT_TX_REQ_DISABLE 9
`define RST_ADDR 32'h0000_0000
`define RST_COUNT 16'h0000
`endif

// File: test/dma_far_side.sv
/*
 * memory seen through the bus matrix: answers each request of the dma channel after 0 to 3 cycles.
 * assumes mem_req stands until the mem_done edge; read data is a fixed function of the address.
 */
`timescale 1ns/1ps
module dma_far_side (
   input wire logic clk,
   input wire logic srst,
   input wire peripheral_dma_channel_pkg::mem_req_t mem_req,
   output logic mem_done,
   output logic [31:0] mem_rdata
);
   int wait_ff;
   // read data only holds in the done cycle; it toggles afterwards so a late sample is caught
   always @(posedge clk) begin
      mem_done <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (srst) begin
         wait_ff <= 0;
         mem_rdata <= 32'h0000_0000;
      end else if (mem_req.valid && !mem_done) begin
         if (wait_ff == 0) begin
            mem_done <= 1'b1;
            if (!mem_req.write) mem_rdata <= mem_req.addr ^ 32'ha5a5_c3c3;
            wait_ff <= $urandom_range(3);
         end else begin
            wait_ff <= wait_ff - 1;
         end
      end
   end
endmodule

// File: test/testbench.sv
/*
 * self-checking bench: a full duplex and a half duplex channel pair, each with its memory model.
 * assumes the design package and the register header are compiled before it.
 */
`timescale 1ns/1ps
`include "peripheral_dma_channel_regs.svh"
module testbench;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [11:0] addr = 12'h000;
   logic [1:0] rd = 2'b00;
   logic [1:0] wr = 2'b00;
   logic [1:0] wreq, mdone, txl;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] hold = 32'h0000_0000;
   logic [31:0] rdata [2], mrd [2], txd [2];
   logic rx_ready = 1'b0;
   logic tx_ready = 1'b0;
   peripheral_dma_channel_pkg::item_size_t isz = peripheral_dma_channel_pkg::size_word;
   peripheral_dma_channel_pkg::item_size_t s;
   peripheral_dma_channel_pkg::mem_req_t mreq [2];
   peripheral_dma_channel_pkg::periph_flags_t flg [2];
   int n_mismatch = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [31:0] q, pa, na;
   // control writes and the status expected after each; entries 8 on go to the half duplex pair
   logic [11:0] ctl_w [15] = '{12'h001, 12'h000, 12'h003, 12'h100, 12'h001, 12'h002, 12'h000, 12'h200,
      12'h100, 12'h001, 12'h200, 12'h001, 12'h002, 12'h100, 12'h002};
   logic [11:0] ctl_e [15] = '{12'h001, 12'h001, 12'h000, 12'h100, 12'h101, 12'h100, 12'h100, 12'h000,
      12'h100, 12'h001, 12'h000, 12'h001, 12'h000, 12'h100, 12'h000};

   always #25 clk = ~clk;

   // index 0 is full duplex, index 1 half duplex; peripheral strobes are shared
   for (genvar g = 0; g < 2; g++) begin : gen_ch
      peripheral_dma_channel #(.ADDR_W(12), .HALF_DUPLEX(1'(g))) dut (.clk(clk), .srst(srst), .avs_address(addr),
         .avs_read(rd[g]), .avs_write(wr[g]), .avs_writedata(wdata), .avs_byteenable(4'hf),
         .avs_readdata(rdata[g]), .avs_waitrequest(wreq[g]), .rx_ready(rx_ready), .rx_holding_reg(hold),
         .tx_ready(tx_ready), .tx_holding_reg(txd[g]), .tx_load(txl[g]), .item_size(isz), .mem_req(mreq[g]),
         .mem_done(mdone[g]), .mem_rdata(mrd[g]), .flags(flg[g]));
      dma_far_side far (.clk(clk), .srst(srst), .mem_req(mreq[g]), .mem_done(mdone[g]), .mem_rdata(mrd[g]));
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // one avalon access; the request holds until waitrequest is sampled low
   task automatic bus(input int c, input bit w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      addr <= a;
      wdata <= d;
      rd[c] <= !w;
      wr[c] <= w;
      // no own limit here: only the hang guard ends a wait
      do begin
         @(posedge clk);
         n++;
      end while (wreq[c] !== 1'b0);
      chk(32'(n), 32'h0000_0002, "bus answer latency");
      q = rdata[c];
      rd[c] <= 1'b0;
      wr[c] <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rdk(input int c, input logic [11:0] a, input logic [31:0] e);
      bus(c, 1'b0, a, 32'h0000_0000);
      chk(q, e, "register read");
   endtask

   function automatic logic [31:0] step(input peripheral_dma_channel_pkg::item_size_t z);
      if (z == peripheral_dma_channel_pkg::size_byte) return 32'h0000_0001;
      if (z == peripheral_dma_channel_pkg::size_half) return 32'h0000_0002;
      return 32'h0000_0004;
   endfunction

   // one item through the full duplex pair, checked at the memory and, for transmit, at the peripheral
   task automatic move(input bit tx, input logic [31:0] ea, input logic [31:0] d);
      int n;
      n = 0;
      hold <= d;
      if (tx) tx_ready <= 1'b1;
      else rx_ready <= 1'b1;
      @(posedge clk);
      rx_ready <= 1'b0;
      tx_ready <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (!(mdone[0] === 1'b1 && mreq[0].valid === 1'b1) && n < 50);
      chk(32'(n < 50), 32'h0000_0001, "memory access");
      chk(32'(mreq[0].write), 32'(!tx), "direction");
      chk(32'(mreq[0].size), 32'(isz), "item size");
      chk(mreq[0].addr, ea, "item address");
      if (!tx) chk(mreq[0].wdata, d, "rx data");
      if (tx) begin
         @(posedge clk);
         chk(32'(txl[0]), 32'h0000_0001, "tx load");
         chk(txd[0], ea ^ 32'ha5a5_c3c3, "tx data");
      end
   endtask

   // a ready strobe with a zero count must not reach memory
   task automatic halt(input bit tx);
      int v;
      v = 0;
      if (tx) tx_ready <= 1'b1;
      else rx_ready <= 1'b1;
      @(posedge clk);
      rx_ready <= 1'b0;
      tx_ready <= 1'b0;
      repeat (10) begin
         @(posedge clk);
         v += int'(mreq[0].valid === 1'b1);
      end
      chk(32'(v), 32'h0000_0000, "halted channel");
   endtask

   // hang guard, about twenty times the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   initial begin
      void'($urandom(32'h0000_735b));
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 10; i++) rdk(0, 12'h100 + 12'(4 * i), 32'h0000_0000);
      rdk(0, 12'h128, 32'h0000_0000);
      chk(32'(flg[0]), 32'h0000_000f, "flags after reset");
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         pa = $urandom();
         bus(0, 1'b1, 12'h100 + 12'(4 * i), pa);
         rdk(0, 12'h100 + 12'(4 * i), i[0] ? pa & 32'h0000_ffff : pa);
      end
      bus(0, 1'b1, `OFS_CHANNEL_STATE, 32'h0000_0101);
      rdk(0, `OFS_CHANNEL_STATE, 32'h0000_0000);
      $display("test registers done");
      for (int i = 0; i < 4; i++) begin
         pa = $urandom();
         bus(1, 1'b1, 12'h100 + 12'(i / 2 * 16 + i % 2 * 4), pa);
         rdk(1, 12'h108 + 12'(i / 2 * 16 + i % 2 * 4), i[0] ? pa & 32'h0000_ffff : pa);
      end
      for (int i = 0; i < 15; i++) begin
         bus(int'(i >= 8), 1'b1, `OFS_CHANNEL_CONTROL, 32'(ctl_w[i]));
         rdk(int'(i >= 8), `OFS_CHANNEL_STATE, 32'(ctl_e[i]));
      end
      rdk(0, `OFS_CHANNEL_CONTROL, 32'h0000_0000);
      $display("test control done");
      pa = $urandom();
      na = $urandom();
      bus(0, 1'b1, `OFS_RX_CUR_ADDR, pa);
      bus(0, 1'b1, `OFS_RX_CUR_COUNT, 32'h0000_0002);
      bus(0, 1'b1, `OFS_RX_NEXT_ADDR, na);
      bus(0, 1'b1, `OFS_RX_NEXT_COUNT, 32'h0000_0001);
      bus(0, 1'b1, `OFS_CHANNEL_CONTROL, 32'h0000_0001);
      chk(32'(flg[0].rx_end_flag), 32'h0000_0000, "rx end clear");
      // byte, half-word and word in turn; the third item runs on the reloaded buffer
      for (int k = 0; k < 3; k++) begin
         s = peripheral_dma_channel_pkg::item_size_t'(k);
         isz <= s;
         move(1'b0, pa, $urandom());
         pa = (k == 1) ? na : pa + step(s);
         rdk(0, `OFS_RX_CUR_ADDR, pa);
         rdk(0, `OFS_RX_CUR_COUNT, 32'(k != 2));
      end
      rdk(0, `OFS_RX_NEXT_ADDR, 32'h0000_0000);
      rdk(0, `OFS_RX_NEXT_COUNT, 32'h0000_0000);
      chk(32'({flg[0].rx_end_flag, flg[0].rx_full_flag}), 32'h0000_0003, "rx flags");
      halt(1'b0);
      bus(0, 1'b1, `OFS_CHANNEL_CONTROL, 32'h0000_0002);
      $display("test receive done");
      pa = $urandom();
      bus(0, 1'b1, `OFS_TX_CUR_ADDR, pa);
      bus(0, 1'b1, `OFS_TX_CUR_COUNT, 32'h0000_0001);
      bus(0, 1'b1, `OFS_TX_NEXT_COUNT, 32'h0000_0000);
      bus(0, 1'b1, `OFS_CHANNEL_CONTROL, 32'h0000_0100);
      chk(32'(flg[0].tx_end_flag), 32'h0000_0000, "tx end clear");
      isz <= peripheral_dma_channel_pkg::size_word;
      move(1'b1, pa, 32'h0000_0000);
      rdk(0, `OFS_TX_CUR_ADDR, pa + 32'h0000_0004);
      rdk(0, `OFS_TX_CUR_COUNT, 32'h0000_0000);
      chk(32'({flg[0].tx_end_flag, flg[0].tx_empty_flag}), 32'h0000_0003, "tx flags");
      halt(1'b1);
      $display("test transmit done");
      give_verdict();
   end
endmodule
